// ===== dv/dtcu_cpu_model.sv
// Purpose: CPU core model on the register bus and vector lines
// Assumes: Writes are one strobe cycle; read data lands one edge later
// Notes:   Bus moves only just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module dtcu_cpu_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic            wr_o,
  output logic [3:0]      vec_o
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    vec_o   = 4'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // Stale data not left on the bus
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask
  // Vector acknowledge pulse
  task automatic vec(input int i);
    @(posedge clk_i);
    vec_o[i] <= 1'b1;
    @(posedge clk_i);
    vec_o[i] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/test_dual_timer_counter_unit.sv
// Purpose: Self-checking bench for the dual timer/counter unit
// Assumes: CPU model drives the bus; bench drives the pins
// Notes:   Timers stopped before counts are read, since reads race counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_dual_timer_counter_unit;
  import dtcu_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic [3:0] vec;
  logic [1:0] ev = 2'b11;
  // Interrupt inputs idle high, active low: matches synchronizer reset level
  logic [1:0] xin = 2'b11;
  logic [1:0] pol = 2'b00;
  logic       xclk = 1'b1;
  logic       xen = 1'b0;
  logic [7:0] d;
  logic [7:0] e;
  logic       ok;
  wire  [7:0] rdata;
  wire  [4:0] obs;
  wire  [1:0] spl;
  int         err_total = 0;
  int         total_checks = 0;
  dtcu_cpu_model u_cpu (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .vec_o(vec));
  dtcu_top u_dut (.CLK_I(clk), .RESET_I(rst), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata),
    .SFR_WR_I(wr), .SFR_RDATA_O(rdata), .TIMER_A_EVENT_PIN_I(ev[0]),
    .TIMER_B_EVENT_PIN_I(ev[1]), .EXT_IRQ_A_INPUT_I(xin[0]), .EXT_IRQ_B_INPUT_I(xin[1]),
    .EXT_IRQ_A_POLARITY_I(pol[0]), .EXT_IRQ_B_POLARITY_I(pol[1]), .EXT_CLK_I(xclk),
    .TIMER_A_VECTOR_I(vec[0]), .TIMER_B_VECTOR_I(vec[1]), .EXT_IRQ_A_VECTOR_I(vec[2]),
    .EXT_IRQ_B_VECTOR_I(vec[3]), .TIMER_A_IRQ_O(obs[0]), .TIMER_B_IRQ_O(obs[1]),
    .EXT_IRQ_A_IRQ_O(obs[2]), .EXT_IRQ_B_IRQ_O(obs[3]), .TIMER_B_OVF_PULSE_O(obs[4]),
    .SPLIT_HIGH_CLOCK_CHOICE_O(spl[1]), .SPLIT_LOW_CLOCK_CHOICE_O(spl[0]));
  initial forever #5 clk = ~clk;
  // Slower than the system clock, idle high outside its window
  initial forever #10.3 xclk = xen ? ~xclk : 1'b1;
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_hi(input int i, input int lim, output logic hit);
    hit = 1'b0;
    for (int k = 0; k < lim && !hit; k++) begin
      @(posedge clk);
      #1;
      hit = (obs[i] === 1'b1);
    end
  endtask
  // Each level held four clocks
  task automatic pins(input logic [1:0] v);
    @(posedge clk);
    ev <= v;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_regs();
    logic [7:0] adr [5] = '{ADDR_CTRL, ADDR_MODE, ADDR_A_LO, ADDR_B_LO, ADDR_CKSEL};
    foreach (adr[k]) begin
      u_cpu.rd(adr[k], d);
      `CHK("reset_value", 8'h00, d)
    end
    u_cpu.wr(ADDR_CKSEL, 8'hFF);
    u_cpu.rd(ADDR_CKSEL, d);
    `CHK("cksel_mask", 8'h7B, d)
    `CHK("split_choice", 2'b11, spl)
    u_cpu.wr(ADDR_CKSEL, 8'h20);
    #1 `CHK("split_choice", 2'b01, spl)
    u_cpu.wr(ADDR_A_LO, 8'h55);
    u_cpu.rd(ADDR_A_LO, d);
    `CHK("a_lo", 8'h55, d)
    u_cpu.wr(ADDR_B_LO, 8'hAA);
    u_cpu.rd(ADDR_B_LO, d);
    `CHK("b_lo", 8'hAA, d)
    u_cpu.wr(8'h8E, 8'h5A);
    u_cpu.rd(8'h8E, d);
    `CHK("unmapped", 8'h00, d)
  endtask
  task automatic t_wrap(input logic [7:0] m, input logic [7:0] lo);
    u_cpu.wr(ADDR_CKSEL, 8'h08);
    u_cpu.wr(ADDR_MODE, m);
    u_cpu.wr(ADDR_A_HI, 8'hFF);
    u_cpu.wr(ADDR_A_LO, lo);
    repeat (4) @(posedge clk);
    u_cpu.rd(ADDR_A_LO, d);
    `CHK("a_idle", lo, d)
    u_cpu.wr(ADDR_CTRL, 8'h10);
    wait_hi(0, 8, ok);
    `CHK("a_wrap", 1'b1, ok)
    if (m == 8'h00) u_cpu.wr(ADDR_CTRL, 8'h10);
    else u_cpu.vec(0);
    @(posedge clk);
    #1 `CHK("a_flag_clear", 1'b0, obs[0])
    u_cpu.wr(ADDR_CTRL, 8'h00);
    u_cpu.rd(ADDR_A_HI, d);
    `CHK("a_hi_wrap", 8'h00, d)
  endtask
  task automatic t_reload();
    u_cpu.wr(ADDR_CKSEL, 8'h18);
    u_cpu.wr(ADDR_MODE, 8'h22);
    u_cpu.wr(ADDR_A_HI, 8'hF0);
    u_cpu.wr(ADDR_A_LO, 8'hFE);
    u_cpu.wr(ADDR_B_HI, 8'hF0);
    u_cpu.wr(ADDR_B_LO, 8'hFE);
    u_cpu.wr(ADDR_CTRL, 8'h50);
    wait_hi(4, 8, ok);
    `CHK("b_pulse", 1'b1, ok)
    `CHK("b_flag", 1'b1, obs[1])
    `CHK("a_reload_flag", 1'b1, obs[0])
    u_cpu.vec(1);
    #1 `CHK("b_flag_clear", 1'b0, obs[1])
    u_cpu.wr(ADDR_CTRL, 8'h00);
    u_cpu.rd(ADDR_B_LO, d);
    `CHK("b_reload", 4'hF, d[7:4])
    u_cpu.rd(ADDR_B_HI, d);
    `CHK("b_hi_kept", 8'hF0, d)
  endtask
  task automatic t_event();
    u_cpu.wr(ADDR_MODE, 8'h55);
    u_cpu.wr(ADDR_A_LO, 8'h00);
    u_cpu.wr(ADDR_B_LO, 8'h00);
    u_cpu.wr(ADDR_CTRL, 8'h50);
    u_cpu.rd(ADDR_CTRL, d);
    `CHK("run_bits", 8'h50, d)
    repeat (3) begin
      pins(2'b00);
      pins(2'b11);
    end
    repeat (6) @(posedge clk);
    u_cpu.wr(ADDR_CTRL, 8'h00);
    u_cpu.rd(ADDR_A_LO, d);
    `CHK("a_events", 8'h03, d)
    u_cpu.rd(ADDR_B_LO, d);
    `CHK("b_events", 8'h03, d)
  endtask
  task automatic t_gate();
    u_cpu.wr(ADDR_CKSEL, 8'h08);
    u_cpu.wr(ADDR_MODE, 8'h09);
    u_cpu.wr(ADDR_A_LO, 8'h00);
    for (int g = 0; g < 2; g++) begin
      u_cpu.wr(ADDR_CTRL, 8'h10);
      repeat (20) @(posedge clk);
      u_cpu.wr(ADDR_CTRL, 8'h00);
      u_cpu.rd(ADDR_A_LO, d);
      if (g == 0) `CHK("gate_closed", 8'h00, d)
      else `CHK("gate_open", 1'b1, (d >= 8'h12 && d <= 8'h18))
      @(posedge clk);
      xin[0] <= (g == 0) ? pol[0] : ~pol[0];
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic t_ext();
    @(posedge clk);
    pol <= 2'b01;
    xin <= 2'b10;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      u_cpu.wr(ADDR_CTRL, (i == 1) ? 8'h04 : 8'h01);
      @(posedge clk);
      xin[i] <= pol[i];
      wait_hi(2 + i, 8, ok);
      `CHK("edge_set", 1'b1, ok)
      @(posedge clk);
      xin[i] <= ~pol[i];
      repeat (6) @(posedge clk);
      #1 `CHK("edge_held", 1'b1, obs[2 + i])
      u_cpu.vec(2 + i);
      @(posedge clk);
      #1 `CHK("edge_clear", 1'b0, obs[2 + i])
      u_cpu.wr(ADDR_CTRL, 8'h00);
      @(posedge clk);
      xin[i] <= pol[i];
      wait_hi(2 + i, 8, ok);
      `CHK("level_set", 1'b1, ok)
      @(posedge clk);
      xin[i] <= ~pol[i];
      repeat (6) @(posedge clk);
      #1 `CHK("level_off", 1'b0, obs[2 + i])
    end
  endtask
  task automatic t_split();
    u_cpu.wr(ADDR_CKSEL, 8'h18);
    u_cpu.wr(ADDR_A_LO, 8'h00);
    u_cpu.wr(ADDR_A_HI, 8'hFE);
    u_cpu.wr(ADDR_B_HI, 8'hFF);
    u_cpu.wr(ADDR_B_LO, 8'hF8);
    u_cpu.wr(ADDR_MODE, 8'h17);
    wait_hi(4, 16, ok);
    `CHK("split_b_pulse", 1'b1, ok)
    `CHK("split_b_noflag", 1'b0, obs[1])
    u_cpu.rd(ADDR_A_HI, d);
    `CHK("split_hi_idle", 8'hFE, d)
    u_cpu.wr(ADDR_CTRL, 8'h40);
    wait_hi(1, 8, ok);
    `CHK("split_hi_flag", 1'b1, ok)
    u_cpu.rd(ADDR_A_LO, d);
    `CHK("split_lo_idle", 8'h00, d)
    u_cpu.wr(ADDR_CTRL, 8'h50);
    repeat (2) begin
      pins(2'b00);
      pins(2'b11);
    end
    repeat (6) @(posedge clk);
    u_cpu.wr(ADDR_CTRL, 8'h00);
    u_cpu.rd(ADDR_A_LO, d);
    `CHK("split_lo_events", 8'h02, d)
    u_cpu.wr(ADDR_MODE, 8'h37);
    u_cpu.rd(ADDR_B_LO, d);
    repeat (10) @(posedge clk);
    u_cpu.rd(ADDR_B_LO, e);
    `CHK("split_b_stop", d, e)
  endtask
  task automatic t_presc();
    int x;
    u_cpu.wr(ADDR_MODE, 8'h01);
    for (int s = 0; s < 4; s++) begin
      x = (s == 0) ? 20 : (s == 1) ? 60 : (s == 2) ? 5 : 14;
      u_cpu.wr(ADDR_CKSEL, 8'(s));
      u_cpu.wr(ADDR_A_LO, 8'h00);
      xen = (s == 3);
      u_cpu.wr(ADDR_CTRL, 8'h10);
      repeat (240) @(posedge clk);
      u_cpu.wr(ADDR_CTRL, 8'h00);
      u_cpu.rd(ADDR_A_LO, d);
      `CHK("prescale", 1'b1, (d >= 8'(x - 2) && d <= 8'(x + 2)))
    end
    xen = 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_wrap(8'h00, 8'h1E);
    t_wrap(8'h01, 8'hFD);
    t_reload();
    t_event();
    t_gate();
    t_ext();
    t_split();
    t_presc();
    report_and_stop();
  end
  // Whole run needs about 1400 cycles
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== rtl/dtcu_pkg.sv
// Purpose: Constants for the dual timer/counter unit
// Assumes: Byte-wide special function register bus, 100 MHz CLK_I
// Notes:   Functional notes
//
// Functional notes
// - Split mode: low byte runs on timer A controls
// - Split high byte counts internal clocks only
// - Split high byte: B run enables, sets B flag
// - Split: timer B no events, no flag
// - Split: timer B overflow pulses still exported
// - Split: timer B runs unless mode 3
// - Overflow flags set; software or vector clears
// - Run bits enable timers when set
// - External flags: edge sticky, level follows input
// - Type bit: 0 level, 1 edge
// - Gate requires active external input to run
// - Count select: internal clock or pin falls
// - Mode field: 13, 16, 8-reload, split/inactive
// - Clock choice: prescaled or system clock
// - Prescale: /12, /4, /48, external /8
// - External clock synchronized, not above system clock
// - Third timer clock choices stored, exported
// - Clock select bits 7, 2 read zero
// - Low bytes readable, writable, reset zero
// - Mode 0 wraps at 0x1FFF, sets flag
// - Mode 2 reloads low from high byte
// - Run bit keeps count, never reloads
package dtcu_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h88;
  localparam logic [7:0] ADDR_MODE   = 8'h89;
  localparam logic [7:0] ADDR_A_LO   = 8'h8A;
  localparam logic [7:0] ADDR_B_LO   = 8'h8B;
  localparam logic [7:0] ADDR_A_HI   = 8'h8C;
  localparam logic [7:0] ADDR_B_HI   = 8'h8D;
  localparam logic [7:0] ADDR_CKSEL  = 8'h8F;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] CKSEL_MASK  = 8'h7B;
  // Control/status bit positions
  localparam int CT_B_FLAG = 7;
  localparam int CT_B_RUN  = 6;
  localparam int CT_A_FLAG = 5;
  localparam int CT_A_RUN  = 4;
  localparam int CT_XB_FLG = 3;
  localparam int CT_XB_EDG = 2;
  localparam int CT_XA_FLG = 1;
  localparam int CT_XA_EDG = 0;
  // Mode register bit positions
  localparam int MD_B_GATE = 7;
  localparam int MD_B_CNT  = 6;
  localparam int MD_B_MODE = 4;
  localparam int MD_A_GATE = 3;
  localparam int MD_A_CNT  = 2;
  localparam int MD_A_MODE = 0;
  // Clock select bit positions
  localparam int CK_SPL_HI = 6;
  localparam int CK_SPL_LO = 5;
  localparam int CK_B_SYS  = 4;
  localparam int CK_A_SYS  = 3;
  localparam int CK_PRE    = 0;
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } dtcu_mode_e;
  typedef enum logic [1:0] {
    PRE_DIV12 = 2'b00,
    PRE_DIV4  = 2'b01,
    PRE_DIV48 = 2'b10,
    PRE_EXT8  = 2'b11
  } dtcu_pre_e;
  localparam logic [5:0] DIV_12    = 6'h0C;
  localparam logic [5:0] DIV_4     = 6'h04;
  localparam logic [5:0] DIV_48    = 6'h30;
  localparam logic [5:0] DIV_EXT   = 6'h08;
  localparam int         SYNC_N    = 5;
  localparam int         IN_EV_A   = 0;
  localparam int         IN_EV_B   = 1;
  localparam int         IN_INT_A  = 2;
  localparam int         IN_INT_B  = 3;
  localparam int         IN_EXTCLK = 4;
endpackage

// ===== rtl/dtcu_prescaler.sv
// Purpose: Shared prescaled clock enable for both timers
// Assumes: External clock already synchronized, one pulse per fall
// Notes:   Divider changes take effect at once, without waiting for the wrap
`timescale 1ns/1ps
`default_nettype none
module dtcu_prescaler
  import dtcu_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic [1:0] sel_i,
  input  wire logic      ext_fall_i,
  output logic           tick_o
);
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [5:0] limit;
  logic       adv;

  always_comb begin
    case (sel_i)
      PRE_DIV12: limit = DIV_12;
      PRE_DIV4:  limit = DIV_4;
      PRE_DIV48: limit = DIV_48;
      default:   limit = DIV_EXT;
    endcase
    adv    = (sel_i == PRE_EXT8) ? ext_fall_i : 1'b1;
    tick_o = adv && (cnt_reg >= limit - 6'h01);
    if (!adv) begin
      cnt_next = cnt_reg;
    end else if (tick_o) begin
      cnt_next = 6'h00;
    end else begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  sequence s_div4_hold;
    tick_o && sel_i == PRE_DIV4 ##1 (sel_i == PRE_DIV4)[*4];
  endsequence
  property p_div4;
    @(posedge clk_i) disable iff (rst_i)
    s_div4_hold |-> tick_o && !$past(tick_o) && !$past(tick_o, 2) && !$past(tick_o, 3);
  endproperty
  a_div4: assert property (p_div4) else $error("divide by 4 period wrong");
endmodule
`default_nettype wire

// ===== rtl/dtcu_sync_edge.sv
// Purpose: Two-flop synchronizer with falling edge detect
// Assumes: Input is asynchronous to CLK_I
// Notes:   First flop feeds only the second flop
`timescale 1ns/1ps
`default_nettype none
module dtcu_sync_edge (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      level_o,
  output logic      fall_o
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic meta_next;
  logic sync_next;
  logic prev_next;

  always_comb begin
    meta_next = d_i;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level_o = sync_reg;
  assign fall_o  = prev_reg & ~sync_reg;

  property p_fall_one;
    @(posedge clk_i) disable iff (rst_i) fall_o |=> !fall_o;
  endproperty
  a_fall_one: assert property (p_fall_one) else $error("fall pulse longer than one cycle");
endmodule
`default_nettype wire

// ===== rtl/dtcu_top.sv
// Purpose: Two counter/timers with control, mode and clock registers
// Assumes: Byte SFR bus, write strobe, read data one cycle after address
// Notes:   Register write wins over a count in the same cycle
`timescale 1ns/1ps
`default_nettype none
module dtcu_top
  import dtcu_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RESET_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  input  wire logic       SFR_WR_I,
  output logic [7:0]      SFR_RDATA_O,
  input  wire logic       TIMER_A_EVENT_PIN_I,
  input  wire logic       TIMER_B_EVENT_PIN_I,
  input  wire logic       EXT_IRQ_A_INPUT_I,
  input  wire logic       EXT_IRQ_B_INPUT_I,
  input  wire logic       EXT_IRQ_A_POLARITY_I,
  input  wire logic       EXT_IRQ_B_POLARITY_I,
  input  wire logic       EXT_CLK_I,
  input  wire logic       TIMER_A_VECTOR_I,
  input  wire logic       TIMER_B_VECTOR_I,
  input  wire logic       EXT_IRQ_A_VECTOR_I,
  input  wire logic       EXT_IRQ_B_VECTOR_I,
  output logic            TIMER_A_IRQ_O,
  output logic            TIMER_B_IRQ_O,
  output logic            EXT_IRQ_A_IRQ_O,
  output logic            EXT_IRQ_B_IRQ_O,
  output logic            TIMER_B_OVF_PULSE_O,
  output logic            SPLIT_HIGH_CLOCK_CHOICE_O,
  output logic            SPLIT_LOW_CLOCK_CHOICE_O
);
  import dtcu_pkg::*;

  logic [7:0] ctrl_reg,   ctrl_next;
  logic [7:0] mode_reg,   mode_next;
  logic [7:0] cksel_reg,  cksel_next;
  logic [7:0] a_lo_reg,   a_lo_next;
  logic [7:0] a_hi_reg,   a_hi_next;
  logic [7:0] b_lo_reg,   b_lo_next;
  logic [7:0] b_hi_reg,   b_hi_next;
  logic [7:0] rdata_reg,  rdata_next;
  logic       act_a_reg,  act_a_next;
  logic       act_b_reg,  act_b_next;
  logic       pulse_reg,  pulse_next;

  logic [SYNC_N-1:0] raw_in;
  logic [SYNC_N-1:0] sync_lvl;
  logic [SYNC_N-1:0] sync_fall;
  logic              pre_tick;
  logic [1:0]        a_mode;
  logic [1:0]        b_mode;
  logic              split;
  logic              act_a;
  logic              act_b;
  logic              int_tick_a;
  logic              int_tick_b;
  logic              tick_a;
  logic              tick_b;
  logic              run_a;
  logic              run_b;
  logic              hi_run;
  logic [16:0]       step_a;
  logic [16:0]       step_b;
  logic              ovf_a;
  logic              ovf_b;
  logic              ovf_hi;
  logic              set_fa;
  logic              set_fb;
  logic              wr_ctrl;

  assign raw_in = {EXT_CLK_I, EXT_IRQ_B_INPUT_I, EXT_IRQ_A_INPUT_I,
                   TIMER_B_EVENT_PIN_I, TIMER_A_EVENT_PIN_I};

  // Event, interrupt and external clock pins cross two flops before any use
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      dtcu_sync_edge u_sync (
        .clk_i   (CLK_I),
        .rst_i   (RESET_I),
        .d_i     (raw_in[gi]),
        .level_o (sync_lvl[gi]),
        .fall_o  (sync_fall[gi])
      );
    end
  endgenerate

  dtcu_prescaler u_pre (
    .clk_i      (CLK_I),
    .rst_i      (RESET_I),
    .sel_i      (cksel_reg[CK_PRE +: 2]),
    .ext_fall_i (sync_fall[IN_EXTCLK]),
    .tick_o     (pre_tick)
  );

  // One increment of a timer pair; bit 16 is the overflow
  function automatic logic [16:0] step(input logic [1:0] md, input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [13:0] v13;
    logic [16:0] v16;
    logic [8:0]  v8;
    v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    v16 = {1'b0, hi, lo} + 17'h00001;
    v8  = {1'b0, lo} + 9'h001;
    case (md)
      MODE_13BIT:  step = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
      MODE_16BIT:  step = v16;
      MODE_RELOAD: step = {v8[8], hi, v8[8] ? hi : v8[7:0]};
      default:     step = {v8[8], hi, v8[7:0]};
    endcase
  endfunction

  always_comb begin
    a_mode     = mode_reg[MD_A_MODE +: 2];
    b_mode     = mode_reg[MD_B_MODE +: 2];
    split      = (a_mode == MODE_SPLIT);
    act_a      = EXT_IRQ_A_POLARITY_I ? sync_lvl[IN_INT_A] : ~sync_lvl[IN_INT_A];
    act_b      = EXT_IRQ_B_POLARITY_I ? sync_lvl[IN_INT_B] : ~sync_lvl[IN_INT_B];
    int_tick_a = cksel_reg[CK_A_SYS] ? 1'b1 : pre_tick;
    int_tick_b = cksel_reg[CK_B_SYS] ? 1'b1 : pre_tick;
    tick_a     = mode_reg[MD_A_CNT] ? sync_fall[IN_EV_A] : int_tick_a;
    // Split mode takes timer B off its event pin
    tick_b     = (mode_reg[MD_B_CNT] && !split) ? sync_fall[IN_EV_B] : int_tick_b;
    run_a      = ctrl_reg[CT_A_RUN] && (!mode_reg[MD_A_GATE] || act_a);
    if (split) begin
      run_b = (b_mode != MODE_SPLIT);
    end else begin
      run_b = ctrl_reg[CT_B_RUN] && (!mode_reg[MD_B_GATE] || act_b)
              && (b_mode != MODE_SPLIT);
    end
    hi_run  = split && ctrl_reg[CT_B_RUN] && int_tick_a;
    step_a  = step(a_mode, a_hi_reg, a_lo_reg);
    step_b  = step(b_mode, b_hi_reg, b_lo_reg);
    ovf_a   = run_a && tick_a && step_a[16];
    ovf_b   = run_b && tick_b && step_b[16];
    ovf_hi  = hi_run && (a_hi_reg == 8'hFF);
    set_fa  = ovf_a;
    set_fb  = split ? ovf_hi : ovf_b;
    wr_ctrl = SFR_WR_I && (SFR_ADDR_I == ADDR_CTRL);

    // Counting keeps the held value; run never reloads
    a_lo_next = a_lo_reg;
    a_hi_next = a_hi_reg;
    b_lo_next = b_lo_reg;
    b_hi_next = b_hi_reg;
    if (run_a && tick_a) begin
      a_lo_next = step_a[7:0];
      if (!split) begin
        a_hi_next = step_a[15:8];
      end
    end
    if (hi_run) begin
      a_hi_next = a_hi_reg + 8'h01;
    end
    if (run_b && tick_b) begin
      {b_hi_next, b_lo_next} = step_b[15:0];
    end
    pulse_next = ovf_b;

    mode_next  = mode_reg;
    cksel_next = cksel_reg;
    ctrl_next  = ctrl_reg;
    if (SFR_WR_I) begin
      case (SFR_ADDR_I)
        ADDR_CTRL:  ctrl_next  = SFR_WDATA_I;
        ADDR_MODE:  mode_next  = SFR_WDATA_I;
        ADDR_A_LO:  a_lo_next  = SFR_WDATA_I;
        ADDR_B_LO:  b_lo_next  = SFR_WDATA_I;
        ADDR_A_HI:  a_hi_next  = SFR_WDATA_I;
        ADDR_B_HI:  b_hi_next  = SFR_WDATA_I;
        ADDR_CKSEL: cksel_next = SFR_WDATA_I & CKSEL_MASK;
        default:    ;
      endcase
    end

    // Clears first, then hardware sets so no event is lost
    if (TIMER_A_VECTOR_I) begin
      ctrl_next[CT_A_FLAG] = 1'b0;
    end
    if (TIMER_B_VECTOR_I) begin
      ctrl_next[CT_B_FLAG] = 1'b0;
    end
    ctrl_next[CT_A_FLAG] = ctrl_next[CT_A_FLAG] | set_fa;
    ctrl_next[CT_B_FLAG] = ctrl_next[CT_B_FLAG] | set_fb;

    act_a_next = act_a;
    act_b_next = act_b;
    if (ctrl_reg[CT_XA_EDG]) begin
      if (EXT_IRQ_A_VECTOR_I) begin
        ctrl_next[CT_XA_FLG] = 1'b0;
      end
      ctrl_next[CT_XA_FLG] = ctrl_next[CT_XA_FLG] | (act_a && !act_a_reg);
    end else begin
      ctrl_next[CT_XA_FLG] = act_a;
    end
    if (ctrl_reg[CT_XB_EDG]) begin
      if (EXT_IRQ_B_VECTOR_I) begin
        ctrl_next[CT_XB_FLG] = 1'b0;
      end
      ctrl_next[CT_XB_FLG] = ctrl_next[CT_XB_FLG] | (act_b && !act_b_reg);
    end else begin
      ctrl_next[CT_XB_FLG] = act_b;
    end

    case (SFR_ADDR_I)
      ADDR_CTRL:  rdata_next = ctrl_reg;
      ADDR_MODE:  rdata_next = mode_reg;
      ADDR_A_LO:  rdata_next = a_lo_reg;
      ADDR_B_LO:  rdata_next = b_lo_reg;
      ADDR_A_HI:  rdata_next = a_hi_reg;
      ADDR_B_HI:  rdata_next = b_hi_reg;
      ADDR_CKSEL: rdata_next = cksel_reg & CKSEL_MASK;
      default:    rdata_next = RESET_VALUE;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl_reg  <= RESET_VALUE;
      mode_reg  <= RESET_VALUE;
      cksel_reg <= RESET_VALUE;
      a_lo_reg  <= RESET_VALUE;
      a_hi_reg  <= RESET_VALUE;
      b_lo_reg  <= RESET_VALUE;
      b_hi_reg  <= RESET_VALUE;
      rdata_reg <= RESET_VALUE;
      act_a_reg <= 1'b0;
      act_b_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      mode_reg  <= mode_next;
      cksel_reg <= cksel_next;
      a_lo_reg  <= a_lo_next;
      a_hi_reg  <= a_hi_next;
      b_lo_reg  <= b_lo_next;
      b_hi_reg  <= b_hi_next;
      rdata_reg <= rdata_next;
      act_a_reg <= act_a_next;
      act_b_reg <= act_b_next;
      pulse_reg <= pulse_next;
    end
  end

  assign SFR_RDATA_O               = rdata_reg;
  assign TIMER_A_IRQ_O             = ctrl_reg[CT_A_FLAG];
  assign TIMER_B_IRQ_O             = ctrl_reg[CT_B_FLAG];
  assign EXT_IRQ_A_IRQ_O           = ctrl_reg[CT_XA_FLG];
  assign EXT_IRQ_B_IRQ_O           = ctrl_reg[CT_XB_FLG];
  assign TIMER_B_OVF_PULSE_O       = pulse_reg;
  assign SPLIT_HIGH_CLOCK_CHOICE_O = cksel_reg[CK_SPL_HI];
  assign SPLIT_LOW_CLOCK_CHOICE_O  = cksel_reg[CK_SPL_LO];

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_split_hi_wrap;
    split && ctrl_reg[CT_B_RUN] && int_tick_a && a_hi_reg == 8'hFF;
  endsequence
  property p_split_hi;
    s_split_hi_wrap |=> TIMER_B_IRQ_O && a_hi_reg == 8'h00;
  endproperty
  a_split_hi: assert property (p_split_hi) else $error("split high wrap missed flag");

  property p_no_b_flag;
    $rose(TIMER_B_IRQ_O) && $past(split) |-> $past(ovf_hi) || $past(wr_ctrl);
  endproperty
  a_no_b_flag: assert property (p_no_b_flag) else $error("timer B flag set in split");

  property p_b_pulse;
    split && b_mode == MODE_16BIT && tick_b && {b_hi_reg, b_lo_reg} == 16'hFFFF
      && !SFR_WR_I |=> TIMER_B_OVF_PULSE_O ##1 !TIMER_B_OVF_PULSE_O;
  endproperty
  a_b_pulse: assert property (p_b_pulse) else $error("timer B pulse missing");

  property p_stopped;
    !run_a && !hi_run && !SFR_WR_I |=> $stable(a_lo_reg) && $stable(a_hi_reg);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer A moved");

  property p_mode0_wrap;
    a_mode == MODE_13BIT && run_a && tick_a && a_hi_reg == 8'hFF
      && a_lo_reg[4:0] == 5'h1F && !SFR_WR_I
      |=> TIMER_A_IRQ_O && a_hi_reg == 8'h00 && a_lo_reg[4:0] == 5'h00;
  endproperty
  a_mode0_wrap: assert property (p_mode0_wrap) else $error("mode 0 wrap wrong");

  property p_reload;
    a_mode == MODE_RELOAD && run_a && tick_a && a_lo_reg == 8'hFF && !SFR_WR_I
      |=> a_lo_reg == $past(a_hi_reg) && $stable(a_hi_reg) && TIMER_A_IRQ_O;
  endproperty
  a_reload: assert property (p_reload) else $error("mode 2 reload wrong");

  property p_level;
    !ctrl_reg[CT_XA_EDG] |=> EXT_IRQ_A_IRQ_O == $past(act_a);
  endproperty
  a_level: assert property (p_level) else $error("level flag not following input");

  property p_cksel_zero;
    SFR_ADDR_I == ADDR_CKSEL |=> SFR_RDATA_O[7] == 1'b0 && SFR_RDATA_O[2] == 1'b0;
  endproperty
  a_cksel_zero: assert property (p_cksel_zero) else $error("unused clock bits not zero");

  property p_event_count;
    mode_reg[MD_A_CNT] && !sync_fall[IN_EV_A] && !SFR_WR_I && !hi_run |=> $stable(a_lo_reg);
  endproperty
  a_event_count: assert property (p_event_count) else $error("count without pin fall");
endmodule
`default_nettype wire
